//--- shared/hsc_map.svh
// Register offsets, field positions, reset values and timing counts of the schedule control.
`ifndef HSC_MAP_SVH
`define HSC_MAP_SVH
`define HSC_OFS_CMD 8'h00
`define HSC_OFS_STS 8'h04
`define HSC_OFS_FIDX 8'h08
`define HSC_OFS_CAP 8'h0c
`define HSC_OFS_ALA 8'h10
`define HSC_CMD_RUN 0
`define HSC_CMD_ASE 5
`define HSC_STS_HALT 12
`define HSC_STS_ASS 15
`define HSC_IST_FRAME 7
`define HSC_ALA_LSB 5
`define HSC_ALA_RST 32'h0000_0000
`define HSC_FIDX_RST 14'h0000
`define HSC_THRESH_RST 8'h00
`define HSC_CLK_NS 20
`define HSC_UFRAME_NS 125000
`define HSC_UFRAME_CYC (`HSC_UFRAME_NS / `HSC_CLK_NS)
`define HSC_UF_LAST 3'h7
`define HSC_UF_PER_FRAME 4'h8
`endif

//--- shared/hsc_pkg.sv
// Types and the caching model decode shared by the schedule control modules.
package hsc_pkg;
  typedef enum logic [4:0] {
    hsc_st_idle = 5'b00001,
    hsc_st_decide = 5'b00010,
    hsc_st_fetch = 5'b00100,
    hsc_st_exec = 5'b01000,
    hsc_st_advance = 5'b10000
  } hsc_async_state_t;
  typedef enum logic [1:0] {
    hsc_no_cache = 2'h0,
    hsc_uf_cache = 2'h1,
    hsc_frame_cache = 2'h2
  } hsc_cache_model_t;
  // The frame bit takes priority over the micro-frame count.
  function automatic hsc_cache_model_t hsc_model(input logic [7:0] thr);
    if (thr[7]) begin
      return hsc_frame_cache;
    end
    if (thr[2:0] != 3'h0) begin
      return hsc_uf_cache;
    end
    return hsc_no_cache;
  endfunction : hsc_model
endpackage : hsc_pkg

//--- shared/hsc_sched_if.sv
// Micro-frame timing and periodic cache signals between the schedule control modules.
interface hsc_sched_if;
  logic uf_start;
  logic uf_end;
  logic [13:0] frame_index;
  logic run;
  logic fidx_we;
  logic [13:0] fidx_wdata;
  logic [7:0] threshold;
  logic flush;
  logic restart;
  logic [3:0] window;
  logic [2:0] desc_slot;
  modport timer (input run, fidx_we, fidx_wdata, output uf_start, uf_end, frame_index);
  modport cache (input uf_start, uf_end, frame_index, threshold,
                 output flush, restart, window, desc_slot);
  modport ctrl (output run, fidx_we, fidx_wdata, threshold,
                input uf_start, uf_end, frame_index, flush, restart, window, desc_slot);
endinterface : hsc_sched_if

//--- src/hsc_uframe_timer.sv
// Micro-frame timer and frame index counter.
`include "hsc_map.svh"
module hsc_uframe_timer #(
  parameter int UFRAME_CYCLES = `HSC_UFRAME_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Timing towards the controller.
  hsc_sched_if.timer sif
);
  localparam logic [12:0] LAST = 13'(UFRAME_CYCLES - 1);
  logic [12:0] cnt_ff;
  logic [13:0] fidx_ff;

  assign sif.uf_start = sif.run && (cnt_ff == 13'h0000);
  assign sif.uf_end = sif.run && (cnt_ff == LAST);
  assign sif.frame_index = fidx_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !sif.run || cnt_ff == LAST) begin
      cnt_ff <= 13'h0000;
    end else begin
      cnt_ff <= cnt_ff + 13'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fidx_ff <= `HSC_FIDX_RST;
    end else if (sif.fidx_we && !sif.run) begin
      fidx_ff <= sif.fidx_wdata;
    end else if (sif.uf_end) begin
      fidx_ff <= fidx_ff + 14'h0001;
    end
  end
endmodule : hsc_uframe_timer

//--- src/hsc_periodic_cache.sv
// Periodic schedule state retention according to the advertised caching model.
`include "hsc_map.svh"
module hsc_periodic_cache (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Timing in, cache control out.
  hsc_sched_if.cache sif
);
  hsc_pkg::hsc_cache_model_t model;
  logic frame_last;
  logic frame_first;
  logic flush_ff;
  logic restart_ff;
  logic [3:0] window_ff;
  logic [2:0] slot_ff;

  assign model = hsc_pkg::hsc_model(sif.threshold);
  assign frame_last = sif.frame_index[2:0] == `HSC_UF_LAST;
  assign frame_first = sif.frame_index[2:0] == 3'h0;
  assign sif.flush = flush_ff;
  assign sif.restart = restart_ff;
  assign sif.window = window_ff;
  assign sif.desc_slot = slot_ff;

  // Each micro-frame end releases the current state; frame caching keeps it to the frame end.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flush_ff <= 1'b0;
    end else begin
      flush_ff <= sif.uf_end && (model != hsc_pkg::hsc_frame_cache || frame_last);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= sif.uf_start && (model != hsc_pkg::hsc_frame_cache || frame_first);
    end
  end

  // Window of micro-frames held on chip, counting the current one.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      window_ff <= 4'h1;
    end else if (sif.uf_start) begin
      unique case (model)
        hsc_pkg::hsc_no_cache: window_ff <= 4'h1;
        hsc_pkg::hsc_uf_cache: window_ff <= {1'b0, sif.threshold[2:0]};
        hsc_pkg::hsc_frame_cache: window_ff <= `HSC_UF_PER_FRAME;
        default: window_ff <= 4'h1;
      endcase
    end
  end

  // One descriptor spans eight micro-frames; the low index bits pick its record.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      slot_ff <= 3'h0;
    end else if (sif.uf_start) begin
      slot_ff <= sif.frame_index[2:0];
    end
  end
endmodule : hsc_periodic_cache

//--- src/hsc_schedule_ctrl.sv
// Schedule control top: registers, asynchronous list walker and periodic caching.
//
// The register addresses and strobed register access were decided locally.
`include "hsc_map.svh"
// Functional notes
// - Threshold of zero selects the no-caching model for periodic structures.
// - No caching: periodic state is discarded at every micro-frame end.
// - No caching: periodic traversal restarts from the frame list each micro-frame.
// - Threshold bit seven set: structures are held for a whole eight micro-frame frame.
// - Low three threshold bits nonzero: hold state for that many micro-frames.
// - Micro-frame caching: release current state at each boundary, accumulate next.
// - A descriptor covers eight micro-frames; its record is chosen by index.
// - Enable clear: no list access. Enable set: walk list from list address.
// - The enable bit is sampled only when the next queue head is needed.
// - Status bit shows the real running state of the asynchronous schedule.
// - Control and bulk transfers are served through queue heads.
// - List address is undefined after reset (the code's reset loads zero); schedule disabled while enable clear.
// - Service starts by fetching the queue head at the list address.
// - On finishing, the last horizontal link stays in the list address.
// - Processing ends at micro-frame end, on empty list, or when disabled.
module hsc_schedule_ctrl #(
  parameter logic [7:0] ISO_THRESHOLD = `HSC_THRESH_RST,
  parameter int UFRAME_CYCLES = `HSC_UFRAME_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Queue head fetch.
  output logic qh_rd_req,
  output logic [31:0] qh_rd_addr,
  input wire logic qh_rd_ack,
  input wire logic [31:0] qh_hlink,
  input wire logic qh_list_empty,
  // Queue head execution.
  output logic xact_req,
  output logic [31:0] xact_qh_addr,
  input wire logic xact_done,
  // Periodic schedule control, frame index and asynchronous schedule status.
  output logic per_flush,
  output logic per_restart,
  output logic [3:0] per_window,
  output logic [2:0] per_desc_slot,
  output logic [13:0] frame_index,
  output logic async_running
);
  hsc_sched_if sif ();

  hsc_pkg::hsc_async_state_t state_ff;
  hsc_pkg::hsc_async_state_t nxt_state;
  hsc_pkg::hsc_cache_model_t model;
  logic run_ff;
  logic ase_ff;
  logic sts_ff;
  logic stop_ff;
  logic empty_ff;
  logic [31:0] ala_ff;
  logic [31:0] hlink_ff;
  logic [31:0] cur_qh_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;
  logic stop_now;

  // Register index match, shared by the write and read paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  hsc_uframe_timer #(
    .UFRAME_CYCLES(UFRAME_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sif(sif.timer)
  );

  hsc_periodic_cache u_cache (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sif(sif.cache)
  );

  assign sif.run = run_ff;
  assign sif.fidx_we = reg_wr && hit(reg_addr, `HSC_OFS_FIDX);
  assign sif.fidx_wdata = reg_wdata[13:0];
  assign sif.threshold = ISO_THRESHOLD;
  assign model = hsc_pkg::hsc_model(ISO_THRESHOLD);
  assign per_flush = sif.flush;
  assign per_restart = sif.restart;
  assign per_window = sif.window;
  assign per_desc_slot = sif.desc_slot;
  assign frame_index = sif.frame_index;
  assign async_running = sts_ff;
  assign reg_rdata = rdata_ff;
  assign qh_rd_addr = ala_ff;
  assign xact_qh_addr = cur_qh_ff;
  assign qh_rd_req = state_ff == hsc_pkg::hsc_st_fetch;
  assign xact_req = state_ff == hsc_pkg::hsc_st_exec;
  assign stop_now = stop_ff || sif.uf_end;

  // Command register bits.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run_ff <= 1'b0;
      ase_ff <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `HSC_OFS_CMD)) begin
      run_ff <= reg_wdata[`HSC_CMD_RUN];
      ase_ff <= reg_wdata[`HSC_CMD_ASE];
    end
  end

  // List address: software loads it while idle, the walker advances it.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ala_ff <= `HSC_ALA_RST;
    end else if (state_ff == hsc_pkg::hsc_st_advance) begin
      ala_ff <= hlink_ff;
    end else if (reg_wr && hit(reg_addr, `HSC_OFS_ALA) && state_ff == hsc_pkg::hsc_st_idle) begin
      ala_ff <= {reg_wdata[31:`HSC_ALA_LSB], 5'h00};
    end
  end

  // Status follows the enable bit only when the walker decides on the next head.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sts_ff <= 1'b0;
    end else if (state_ff == hsc_pkg::hsc_st_decide) begin
      sts_ff <= ase_ff;
    end
  end

  // A micro-frame end seen mid-walk is kept until the walk stops; the set wins.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stop_ff <= 1'b0;
    end else if (sif.uf_end && state_ff != hsc_pkg::hsc_st_idle) begin
      stop_ff <= 1'b1;
    end else if (state_ff == hsc_pkg::hsc_st_idle) begin
      stop_ff <= 1'b0;
    end
  end

  // Fetched queue head: its address, horizontal link and the empty-list indication.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur_qh_ff <= 32'h0000_0000;
      hlink_ff <= 32'h0000_0000;
      empty_ff <= 1'b0;
    end else if (qh_rd_req && qh_rd_ack) begin
      cur_qh_ff <= ala_ff;
      hlink_ff <= {qh_hlink[31:`HSC_ALA_LSB], 5'h00};
      empty_ff <= qh_list_empty;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      hsc_pkg::hsc_st_idle: begin
        if (sif.uf_start) begin
          nxt_state = hsc_pkg::hsc_st_decide;
        end
      end
      hsc_pkg::hsc_st_decide: begin
        if (ase_ff && !stop_now) begin
          nxt_state = hsc_pkg::hsc_st_fetch;
        end else begin
          nxt_state = hsc_pkg::hsc_st_idle;
        end
      end
      hsc_pkg::hsc_st_fetch: begin
        if (qh_rd_ack && stop_now) begin
          nxt_state = hsc_pkg::hsc_st_idle;
        end else if (qh_rd_ack && qh_list_empty) begin
          nxt_state = hsc_pkg::hsc_st_advance;
        end else if (qh_rd_ack) begin
          nxt_state = hsc_pkg::hsc_st_exec;
        end
      end
      hsc_pkg::hsc_st_exec: begin
        if (xact_done) begin
          nxt_state = hsc_pkg::hsc_st_advance;
        end
      end
      hsc_pkg::hsc_st_advance: begin
        if (stop_ff || empty_ff) begin
          nxt_state = hsc_pkg::hsc_st_idle;
        end else begin
          nxt_state = hsc_pkg::hsc_st_decide;
        end
      end
      default: nxt_state = hsc_pkg::hsc_st_idle;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= hsc_pkg::hsc_st_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(reg_addr, `HSC_OFS_CMD)) begin
      rd_mux[`HSC_CMD_RUN] = run_ff;
      rd_mux[`HSC_CMD_ASE] = ase_ff;
    end else if (hit(reg_addr, `HSC_OFS_STS)) begin
      rd_mux[`HSC_STS_HALT] = !run_ff;
      rd_mux[`HSC_STS_ASS] = sts_ff;
    end else if (hit(reg_addr, `HSC_OFS_FIDX)) begin
      rd_mux = {18'h00000, sif.frame_index};
    end else if (hit(reg_addr, `HSC_OFS_CAP)) begin
      rd_mux = {24'h000000, ISO_THRESHOLD};
    end else if (hit(reg_addr, `HSC_OFS_ALA)) begin
      rd_mux = ala_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_ff <= rd_mux;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_nocache_flush_each: assert property (
    model == hsc_pkg::hsc_no_cache && sif.uf_end |=> per_flush
  ) else $error("no-caching state not dropped at micro-frame end");

  chk_nocache_restart_walk: assert property (
    model == hsc_pkg::hsc_no_cache && sif.uf_start |=> per_restart
  ) else $error("periodic walk not restarted at micro-frame start");

  chk_frame_cache_hold: assert property (
    model == hsc_pkg::hsc_frame_cache && sif.uf_end && sif.frame_index[2:0] != 3'h7
    |=> !per_flush
  ) else $error("frame cache dropped before frame end");

  chk_uf_cache_window: assert property (
    model == hsc_pkg::hsc_uf_cache && sif.uf_start |=> per_window == {1'b0, ISO_THRESHOLD[2:0]}
  ) else $error("micro-frame cache window wrong");

  chk_uf_cache_release: assert property (
    model == hsc_pkg::hsc_uf_cache && sif.uf_end |=> per_flush
  ) else $error("micro-frame state not released at boundary");

  chk_no_access_disabled: assert property (
    qh_rd_req |-> sts_ff
  ) else $error("list fetched while schedule not running");

  chk_enable_sampled_late: assert property (
    state_ff == hsc_pkg::hsc_st_decide |=> sts_ff == $past(ase_ff)
  ) else $error("status did not take enable at decision point");

  chk_status_while_exec: assert property (
    xact_req |-> async_running
  ) else $error("executing while status shows stopped");

  chk_disabled_goes_idle: assert property (
    state_ff == hsc_pkg::hsc_st_decide && !ase_ff |=> state_ff == hsc_pkg::hsc_st_idle && !sts_ff
  ) else $error("disabled schedule did not stop");

  chk_fetch_then_exec: assert property (
    qh_rd_req && qh_rd_ack && !stop_now && !qh_list_empty
    |=> xact_req && xact_qh_addr == $past(ala_ff)
  ) else $error("fetched head not executed");

  chk_round_robin_link: assert property (
    state_ff == hsc_pkg::hsc_st_advance |=> ala_ff == $past(hlink_ff)
  ) else $error("horizontal link not kept in list address");

  chk_end_at_uframe: assert property (
    state_ff == hsc_pkg::hsc_st_advance && stop_ff |=> state_ff == hsc_pkg::hsc_st_idle ##1 !stop_ff
  ) else $error("walk did not end at micro-frame end");

  cov_exec_head: cover property (state_ff == hsc_pkg::hsc_st_exec ##1 xact_done);
  cov_round_robin: cover property (state_ff == hsc_pkg::hsc_st_advance ##1
                                   state_ff == hsc_pkg::hsc_st_decide);
  cov_uframe_stop: cover property (stop_ff && state_ff == hsc_pkg::hsc_st_advance);
  cov_empty_list: cover property (qh_rd_ack && qh_rd_req && qh_list_empty);
endmodule : hsc_schedule_ctrl

//--- verif/hsc_mem_model.sv
// Behavioural system memory holding a circular list of queue heads.
module hsc_mem_model #(
  parameter logic [31:0] BASE = 32'h0000_1220,
  parameter int COUNT = 3
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Test controls.
  input wire logic slow,
  input wire logic empty_mode,
  // Queue head fetch.
  input wire logic qh_rd_req,
  input wire logic [31:0] qh_rd_addr,
  output logic qh_rd_ack,
  output logic [31:0] qh_hlink,
  output logic qh_list_empty,
  // Queue head execution.
  input wire logic xact_req,
  input wire logic [31:0] xact_qh_addr,
  output logic xact_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int fwait;
  int xwait;
  initial begin
    qh_rd_ack = 1'b0;
    xact_done = 1'b0;
    qh_hlink = 32'h0000_0000;
    qh_list_empty = 1'b0;
  end
  always @(posedge sys_clk) begin
    qh_rd_ack <= 1'b0;
    xact_done <= 1'b0;
    // Lines outside an answer show the inverse of their last value.
    qh_hlink <= ~qh_hlink;
    qh_list_empty <= ~qh_list_empty;
    if (!rst_n) begin
      fwait <= 0;
      xwait <= 0;
    end else begin
      if (qh_rd_req && !qh_rd_ack) begin
        if (fwait >= (slow ? 4 : 0)) begin
          qh_rd_ack <= 1'b1;
          // Only queue heads sit in the ring, which closes at the base.
          qh_hlink <= (qh_rd_addr == BASE + 32'(COUNT - 1) * 32'h20) ? BASE : qh_rd_addr + 32'h20;
          qh_list_empty <= empty_mode;
          fwait <= 0;
        end else begin
          fwait <= fwait + 1;
        end
      end
      // Control and bulk work of a queue head ends after a short or long delay.
      if (xact_req && !xact_done) begin
        if (xwait >= (slow ? 9 : 1)) begin
          xact_done <= 1'b1;
          xwait <= 0;
        end else begin
          xwait <= xwait + 1;
        end
      end
    end
  end
endmodule : hsc_mem_model

//--- verif/tb_top.sv
// Testbench of the schedule control: register tasks, walker and periodic checks.
`include "hsc_map.svh"
`define CHK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UFC = 40;
  localparam logic [31:0] HEAD = 32'h0000_1220;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic slow = 1'b0;
  logic empty_mode = 1'b0;
  logic [31:0] rdata0, rdata1, rd0, rd1, qh_rd_addr, qh_hlink, xact_qh_addr, ala;
  logic qh_rd_req, qh_rd_ack, qh_list_empty, xact_req, xact_done, ok;
  logic per_flush0, per_flush1, per_restart0, per_restart1;
  logic [3:0] per_window0, per_window1;
  logic [31:0] fetch_q[$];
  int fails = 0;
  int checks_done = 0;
  int fl0, fl1, rs0, rs1, xact_n, uf_total, n_cyc;

  always #10 sys_clk = ~sys_clk;

  hsc_schedule_ctrl #(.ISO_THRESHOLD(8'h00), .UFRAME_CYCLES(UFC)) i_hsc_schedule_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata0), .qh_rd_req(qh_rd_req),
    .qh_rd_addr(qh_rd_addr), .qh_rd_ack(qh_rd_ack), .qh_hlink(qh_hlink),
    .qh_list_empty(qh_list_empty), .xact_req(xact_req), .xact_qh_addr(xact_qh_addr),
    .xact_done(xact_done), .per_flush(per_flush0), .per_restart(per_restart0),
    .per_window(per_window0), .per_desc_slot(), .frame_index(), .async_running());

  // Frame bit together with low bits: frame caching must win.
  hsc_schedule_ctrl #(.ISO_THRESHOLD(8'h82), .UFRAME_CYCLES(UFC)) i_hsc_schedule_ctrl_b (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata1), .qh_rd_req(), .qh_rd_addr(),
    .qh_rd_ack(1'b0), .qh_hlink(qh_hlink), .qh_list_empty(qh_list_empty), .xact_req(),
    .xact_qh_addr(), .xact_done(1'b0), .per_flush(per_flush1), .per_restart(per_restart1),
    .per_window(per_window1), .per_desc_slot(), .frame_index(), .async_running());

  hsc_mem_model #(.BASE(HEAD), .COUNT(3)) i_hsc_mem_model (
    .sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .empty_mode(empty_mode),
    .qh_rd_req(qh_rd_req), .qh_rd_addr(qh_rd_addr), .qh_rd_ack(qh_rd_ack),
    .qh_hlink(qh_hlink), .qh_list_empty(qh_list_empty), .xact_req(xact_req),
    .xact_qh_addr(xact_qh_addr), .xact_done(xact_done));

  always @(posedge sys_clk) begin
    n_cyc++;
    if (n_cyc >= 5000) begin
      fails++;
      close_out();
    end
    if (rst_n) begin
      if (qh_rd_req === 1'b1 && qh_rd_ack) begin
        fetch_q.push_back(qh_rd_addr);
      end
      xact_n += int'(xact_req & xact_done);
      fl0 += int'(per_flush0);
      fl1 += int'(per_flush1);
      rs0 += int'(per_restart0);
      rs1 += int'(per_restart1);
      uf_total += int'(per_flush0);
    end
  end

  function automatic logic [31:0] ring_next(input logic [31:0] a);
    return (a == HEAD + 32'h40) ? HEAD : a + 32'h20;
  endfunction : ring_next

  task automatic close_out();
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd0 = rdata0;
    rd1 = rdata1;
    @(posedge sys_clk);
  endtask : reg_read

  task automatic poll_sts(input int b, input logic v);
    int i;
    i = 0;
    do begin
      reg_read(`HSC_OFS_STS);
      i++;
    end while (rd0[b] !== v && i < 100);
    `CHK("status bit", v, rd0[b])
  endtask : poll_sts

  // Waits for the start of a micro-frame, then steps off the edge.
  task automatic wait_uf();
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (per_restart0 !== 1'b1 && i < 2 * UFC);
    #1;
  endtask : wait_uf

  initial begin
    {fl0, fl1, rs0, rs1, xact_n, uf_total, n_cyc} = '0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    reg_read(`HSC_OFS_STS);
    `CHK("status after reset", 2'b01, {rd0[`HSC_STS_ASS], rd0[`HSC_STS_HALT]})
    reg_read(`HSC_OFS_CAP);
    `CHK("threshold none", 8'h00, rd0[7:0])
    `CHK("threshold frame", 8'h82, rd1[7:0])
    reg_read(8'h20);
    `CHK("unmapped read", 32'h0000_0000, rd0)
    reg_read(`HSC_OFS_ALA);
    `CHK("list address reset", 32'h0000_0000, rd0)
    reg_write(`HSC_OFS_ALA, 32'h0000_123f);
    reg_read(`HSC_OFS_ALA);
    `CHK("list address", HEAD, rd0)
    reg_write(`HSC_OFS_FIDX, 32'h0000_0005);
    reg_read(`HSC_OFS_FIDX);
    `CHK("frame index", 14'h0005, rd0[13:0])
    reg_write(`HSC_OFS_CMD, 32'h0000_0001);
    wait_uf();
    {fl0, fl1, rs0, rs1} = '0;
    repeat (16 * UFC) @(posedge sys_clk);
    #1;
    `CHK("flush no cache", 16, fl0)
    `CHK("restart no cache", 16, rs0)
    `CHK("flush frame cache", 2, fl1)
    `CHK("restart frame cache", 2, rs1)
    `CHK("window no cache", 4'h1, per_window0)
    `CHK("window frame cache", 4'h8, per_window1)
    `CHK("fetches disabled", 0, fetch_q.size())
    reg_write(`HSC_OFS_FIDX, 32'h0000_3fff);
    reg_write(`HSC_OFS_CMD, 32'h0000_0021);
    poll_sts(`HSC_STS_ASS, 1'b1);
    repeat (3 * UFC) @(posedge sys_clk);
    #1;
    `CHK("first fetch", HEAD, fetch_q[0])
    `CHK("fetch count", 1'b1, fetch_q.size() > 2)
    `CHK("executions", 1'b1, xact_n > 0)
    for (int i = 1; i < fetch_q.size(); i++) begin
      ok = (fetch_q[i] === fetch_q[i - 1]) || (fetch_q[i] === ring_next(fetch_q[i - 1]));
      `CHK("fetch order", 1'b1, ok)
    end
    slow <= 1'b1;
    repeat (2 * UFC) @(posedge sys_clk);
    reg_write(`HSC_OFS_CMD, 32'h0000_0001);
    poll_sts(`HSC_STS_ASS, 1'b0);
    reg_read(`HSC_OFS_ALA);
    ala = rd0;
    fetch_q.delete();
    repeat (3 * UFC) @(posedge sys_clk);
    #1;
    `CHK("fetches after disable", 0, fetch_q.size())
    slow <= 1'b0;
    empty_mode <= 1'b1;
    reg_write(`HSC_OFS_CMD, 32'h0000_0021);
    poll_sts(`HSC_STS_ASS, 1'b1);
    repeat (2 * UFC) @(posedge sys_clk);
    #1;
    `CHK("resume point", ala, fetch_q[0])
    wait_uf();
    fetch_q.delete();
    repeat (4 * UFC) @(posedge sys_clk);
    #1;
    `CHK("one fetch per empty pass", 4, fetch_q.size())
    reg_write(`HSC_OFS_CMD, 32'h0000_0000);
    poll_sts(`HSC_STS_HALT, 1'b1);
    repeat (4) @(posedge sys_clk);
    reg_read(`HSC_OFS_FIDX);
    `CHK("frame index count", 14'(32'h0000_0005 + uf_total), rd0[13:0])
    close_out();
  end
endmodule : tb_top
